// >>> inc/pin_flags_map.svh
// register offsets, field positions and reset values of the pin and overflow flag block
// assumes nothing beyond a SystemVerilog preprocessor
`ifndef PIN_FLAGS_MAP_SVH
`define PIN_FLAGS_MAP_SVH
`define PIN_CONFIG_ADDR 8'h33
`define AUX_STATUS_ADDR 8'h40
`define AUX_FAULT_ADDR 8'h41
`define PIN_THREE_CONTROL_ADDR 8'h42
`define AUX_ALERT_ENABLE_ADDR 8'h32
`define PIN_CONFIG_RESET 8'h00
`define AUX_FAULT_RESET 8'h80
`define PIN_THREE_CONTROL_RESET 8'h00
`define AUX_ALERT_ENABLE_RESET 8'h00
`define CFG_ONE_HI 7
`define CFG_TWO_HI 5
`define CFG_THREE_HI 3
`define PIN_TWO_OUT_BIT 1
`define ALERT_GEN_BIT 7
`define PULL_DOWN_BIT 6
`define WAKE_ALERT_BIT 3
`endif

// >>> inc/pin_flags_pkg.sv
// types for the pin and overflow flag block
// assumes pin_flags_map.svh is compiled alongside
package pin_flags_pkg;
  typedef enum logic [1:0] {
    MODE_SPECIAL = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_ACTIVE_LOW = 2'b10,
    MODE_ACTIVE_HIGH = 2'b11
  } pin_mode_t;
endpackage

// >>> rtl/monitor_pin_and_overflow_flags.sv
// three multipurpose pins, status, latched faults and pin three control
// assumes a register port already decoded by the serial slave, same clock
`timescale 1ns/1ps
`default_nettype none
`include "pin_flags_map.svh"

module monitor_pin_and_overflow_flags
  import pin_flags_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [2:0] PIN_IN,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OE,
  input wire logic ENERGY_OVF,
  input wire logic CHARGE_OVF,
  input wire logic TIME_OVF,
  input wire logic SNAPSHOT_BUSY,
  input wire logic TIMEOUT_WAKE_EN,
  input wire logic STUCK_BUS_WAKE,
  input wire logic ALERT_EVENT,
  output logic INTEGRATION_GATE_INPUT,
  output logic OVERFLOW_ALERT
);

  logic [7:0] pin_config;
  logic [7:0] aux_fault;
  logic [7:0] next_fault;
  logic [7:0] fault_set;
  logic [7:0] aux_alert_enable;
  logic alert_gen;
  logic pull_down;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] pin_active;
  logic [2:0] pin_is_input;
  logic [2:0] pin_fault;
  logic drive_one;
  logic drive_two;
  logic drive_three;
  logic [7:0] aux_status;
  logic [7:0] next_rdata;
  logic [2:0] ovf;
  logic [2:0] ovf_d;
  logic [2:0] ovf_rise;
  logic wake_event;
  logic aux_alert;
  logic wr_config;
  logic wr_fault;
  logic wr_ctrl;
  logic wr_enable;
  pin_mode_t mode [3];

  assign ovf = {ENERGY_OVF, CHARGE_OVF, TIME_OVF};

  // writes to the status address or unmapped ones fall through
  always_comb begin
    wr_config = 1'b0;
    wr_fault = 1'b0;
    wr_ctrl = 1'b0;
    wr_enable = 1'b0;
    if (REG_WR) begin
      if (REG_ADDR == `PIN_CONFIG_ADDR) begin
        wr_config = 1'b1;
      end else if (REG_ADDR == `AUX_FAULT_ADDR) begin
        wr_fault = 1'b1;
      end else if (REG_ADDR == `PIN_THREE_CONTROL_ADDR) begin
        wr_ctrl = 1'b1;
      end else if (REG_ADDR == `AUX_ALERT_ENABLE_ADDR) begin
        wr_enable = 1'b1;
      end
    end
  end

  // two-flop pin synchroniser
  // resets low; reset config keeps pins one and three outputs, pin two the gate input
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  assign mode[0] = pin_mode_t'(pin_config[`CFG_ONE_HI -: 2]);
  assign mode[1] = pin_mode_t'(pin_config[`CFG_TWO_HI -: 2]);
  assign mode[2] = pin_mode_t'(pin_config[`CFG_THREE_HI -: 2]);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      logic active;
      logic is_input;
      always_comb begin
        case (mode[g])
          MODE_ACTIVE_HIGH: begin
            is_input = 1'b1;
            active = sync_b[g];
          end
          MODE_ACTIVE_LOW: begin
            is_input = 1'b1;
            active = ~sync_b[g];
          end
          default: begin
            is_input = 1'b0;
            active = 1'b0;
          end
        endcase
      end
      assign pin_is_input[g] = is_input;
      assign pin_active[g] = active;
      // a pin only faults as an input
      assign pin_fault[g] = active && is_input;
    end
  endgenerate

  assign INTEGRATION_GATE_INPUT = (mode[1] == MODE_SPECIAL) && sync_b[1];

  // pins only ever sink; board pull-ups give the high level
  assign PIN_OUT = 3'h0;

  // pin one drives low only in mode 00
  always_comb begin
    case (mode[0])
      MODE_SPECIAL: drive_one = 1'b1;
      default: drive_one = 1'b0;
    endcase
  end

  // pin two output bit pulls low
  always_comb begin
    case (mode[1])
      MODE_OUTPUT: drive_two = pin_config[`PIN_TWO_OUT_BIT];
      default: drive_two = 1'b0;
    endcase
  end

  // pin three mode picks its driver
  // alert bit pulls pin three low in mode 00, pull-down bit in mode 01
  always_comb begin
    case (mode[2])
      MODE_SPECIAL: drive_three = alert_gen;
      MODE_OUTPUT: drive_three = pull_down;
      default: drive_three = 1'b0;
    endcase
  end

  assign PIN_OE = {drive_three, drive_two, drive_one};

  always_comb begin
    aux_status = 8'h00;
    aux_status[6] = pin_active[0];
    if (mode[1] == MODE_SPECIAL) begin
      aux_status[5] = sync_b[1];
    end else begin
      aux_status[5] = pin_active[1];
    end
    aux_status[4] = pin_active[2];
    aux_status[3] = SNAPSHOT_BUSY;
    aux_status[2:0] = ovf;
  end

  // overflow levels stay high; faults and alerts key on the rise
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_d <= 3'h0;
    end else begin
      ovf_d <= ovf;
    end
  end
  assign ovf_rise = ovf & ~ovf_d;
  // wake only counts with control set
  assign wake_event = STUCK_BUS_WAKE && TIMEOUT_WAKE_EN;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_config <= `PIN_CONFIG_RESET;
    end else if (wr_config) begin
      // reserved bit 0 dropped so it always reads zero
      pin_config <= {REG_WDATA[7:1], 1'b0};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_alert_enable <= `AUX_ALERT_ENABLE_RESET;
    end else if (wr_enable) begin
      // bit 4 reserved; bits 7:5 kept for read-back only
      aux_alert_enable <= {REG_WDATA[7:5], 1'b0, REG_WDATA[3:0]};
    end
  end

  // set sources in register bit order, pin one at bit 6
  assign fault_set = {1'b0, pin_fault[0], pin_fault[1], pin_fault[2], wake_event, ovf_rise};

  // held until written zero
  // set wins over a host clear in one cycle, so no event is lost
  always_comb begin
    next_fault = aux_fault;
    if (wr_fault) begin
      next_fault = {1'b1, REG_WDATA[6:0]};
    end
    next_fault = next_fault | fault_set;
  end

  // pin faults latch, set beats clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aux_fault <= `AUX_FAULT_RESET;
    end else begin
      aux_fault <= next_fault;
    end
  end

  assign aux_alert = |(aux_alert_enable[2:0] & ovf_rise) ||
                     (aux_alert_enable[`WAKE_ALERT_BIT] && wake_event);
  assign OVERFLOW_ALERT = aux_alert;

  // alert bit set wins over clear
  // an enabled overflow or wake alert also latches this bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      alert_gen <= 1'b0;
    end else if (ALERT_EVENT || aux_alert) begin
      alert_gen <= 1'b1;
    end else if (wr_ctrl) begin
      alert_gen <= REG_WDATA[`ALERT_GEN_BIT];
    end
  end

  // pull-down bit kept for output mode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pull_down <= 1'b0;
    end else if (wr_ctrl) begin
      pull_down <= REG_WDATA[`PULL_DOWN_BIT];
    end
  end

  // unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (REG_ADDR == `PIN_CONFIG_ADDR) begin
      next_rdata = pin_config;
    end else if (REG_ADDR == `AUX_STATUS_ADDR) begin
      next_rdata = aux_status;
    end else if (REG_ADDR == `AUX_FAULT_ADDR) begin
      next_rdata = aux_fault;
    end else if (REG_ADDR == `PIN_THREE_CONTROL_ADDR) begin
      next_rdata = {alert_gen, pull_down, 6'h00};
    end else if (REG_ADDR == `AUX_ALERT_ENABLE_ADDR) begin
      next_rdata = aux_alert_enable;
    end
  end

  // one cycle of read latency, data from a flop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule // monitor_pin_and_overflow_flags
`default_nettype wire

// >>> dv/pin_board.sv
// board model of the three pins: pull-ups and outside pull-downs
// assumes the device only ever sinks its pins
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic [2:0] oe,
  input wire logic [2:0] ext_low,
  output logic [2:0] level
);
  // pulled up, so a released pin never keeps a stale low
  assign level = ~(oe | ext_low);
endmodule // pin_board
`default_nettype wire

// >>> dv/pin_flags_checker.sv
// assertions on the pin and overflow flag block
// bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module pin_flags_checker (
  input wire logic CLK, RST_N, REG_WR, ENERGY_OVF, CHARGE_OVF, TIME_OVF,
  input wire logic SNAPSHOT_BUSY, TIMEOUT_WAKE_EN, STUCK_BUS_WAKE, ALERT_EVENT,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input wire logic [2:0] PIN_OE, PIN_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence rd_of(a);
    (REG_ADDR == a && !REG_WR) [*2];
  endsequence
  a_pin_one_low: assert property (REG_WR && REG_ADDR == 8'h33 |=>
    PIN_OE[0] == ($past(REG_WDATA[7:6]) == 2'b00)) else $error("pin one drive wrong");
  a_pin_two_out: assert property (REG_WR && REG_ADDR == 8'h33 |=>
    PIN_OE[1] == ($past(REG_WDATA[5:4]) == 2'b01 && $past(REG_WDATA[1])))
    else $error("pin two drive wrong");
  a_pins_pull_only: assert property (PIN_OUT == 3'h0) else $error("pin driven high");
  a_busy_status: assert property (REG_ADDR == 8'h40 && $stable(SNAPSHOT_BUSY) |=>
    REG_RDATA[3] == $past(SNAPSHOT_BUSY)) else $error("busy status wrong");
  a_energy_status: assert property (REG_ADDR == 8'h40 && $stable(ENERGY_OVF) |=>
    REG_RDATA[2] == $past(ENERGY_OVF)) else $error("overflow status wrong");
  a_ovf_fault: assert property ($rose(ENERGY_OVF) ##1 rd_of(8'h41) |=> REG_RDATA[2])
    else $error("energy fault not latched");
  a_wake_fault: assert property (STUCK_BUS_WAKE && TIMEOUT_WAKE_EN ##1 rd_of(8'h41) |=>
    REG_RDATA[3]) else $error("wake fault not latched");
  a_alert_set: assert property (ALERT_EVENT ##1 rd_of(8'h42) |=> REG_RDATA[7])
    else $error("alert bit not set");
  cover property (REG_WR && REG_ADDR == 8'h42);
  cover property ($rose(ENERGY_OVF));
  cover property (STUCK_BUS_WAKE && TIMEOUT_WAKE_EN);
endmodule // pin_flags_checker
bind monitor_pin_and_overflow_flags pin_flags_checker pin_flags_checker_inst (.*);
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the pin and overflow flag block
// assumes the board model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, wr = 0, e_ovf = 0, c_ovf = 0, t_ovf = 0, busy = 0;
  logic wake_en = 0, wake = 0, alert_ev = 0, gate, ovf_alert;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [2:0] ext_low = 0, pin_in, pin_out, pin_oe;
  int n_mismatch = 0, comparisons = 0;
  monitor_pin_and_overflow_flags monitor_pin_and_overflow_flags_inst (.CLK(clk),
    .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .ENERGY_OVF(e_ovf),
    .CHARGE_OVF(c_ovf), .TIME_OVF(t_ovf), .SNAPSHOT_BUSY(busy), .TIMEOUT_WAKE_EN(wake_en),
    .STUCK_BUS_WAKE(wake), .ALERT_EVENT(alert_ev), .INTEGRATION_GATE_INPUT(gate),
    .OVERFLOW_ALERT(ovf_alert));
  pin_board pin_board_inst (.oe(pin_oe), .ext_low(ext_low), .level(pin_in));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // strobe stays up until a later read or the caller lowers it
  task automatic wr_reg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
  endtask
  // three edges: two for the pin synchronisers, one for read data
  task automatic rd(input logic [7:0] a, e, m = 8'hff);
    addr = a;
    wr = 0;
    repeat (3) @(negedge clk);
    chk(rdata & m, e);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    chk({5'h0, pin_oe}, 8'h01);
    rd(8'h33, 8'h00);
    rd(8'h42, 8'h00);
    {e_ovf, c_ovf, t_ovf, busy} = 4'hf;
    @(negedge clk);
    rd(8'h41, 8'h87, 8'h8f);
    wr_reg(8'h40, 8'h00);
    rd(8'h40, 8'h2f, 8'h3f);
    {e_ovf, c_ovf, t_ovf, busy} = 4'h0;
    rd(8'h41, 8'h87, 8'h8f);
    wr_reg(8'h41, 8'h00);
    rd(8'h41, 8'h80, 8'h8f);
    wr_reg(8'h33, 8'hba);
    chk({5'h0, pin_oe}, 8'h00);
    ext_low = 3'b101;
    rd(8'h40, 8'h70, 8'h70);
    rd(8'h41, 8'hf0, 8'hf0);
    ext_low = 3'b010;
    rd(8'h40, 8'h00, 8'h70);
    wr_reg(8'h41, 8'h00);
    rd(8'h41, 8'h80, 8'hf0);
    ext_low = 3'b011;
    rd(8'h40, 8'h40, 8'h70);
    rd(8'h41, 8'hc0, 8'hf0);
    ext_low = 3'b000;
    wr_reg(8'h33, 8'h56);
    chk({5'h0, pin_oe}, 8'h02);
    wr_reg(8'h42, 8'h40);
    chk({5'h0, pin_oe}, 8'h06);
    wr_reg(8'h42, 8'h80);
    chk({5'h0, pin_oe}, 8'h02);
    wr_reg(8'h33, 8'h00);
    chk({5'h0, pin_oe}, 8'h05);
    repeat (2) @(negedge clk);
    chk({7'h0, gate}, 8'h01);
    wr_reg(8'h42, 8'h00);
    chk({5'h0, pin_oe}, 8'h01);
    wr = 0;
    alert_ev = 1;
    @(negedge clk);
    alert_ev = 0;
    rd(8'h42, 8'h80);
    chk({5'h0, pin_oe}, 8'h05);
    wr_reg(8'h41, 8'h00);
    wr_reg(8'h32, 8'h1c);
    wake_en = 1;
    wake = 1;
    #1 chk({7'h0, ovf_alert}, 8'h01);
    @(negedge clk);
    wake = 0;
    rd(8'h41, 8'h88, 8'h8f);
    rd(8'h32, 8'h0c);
    e_ovf = 1;
    #1 chk({7'h0, ovf_alert}, 8'h01);
    @(negedge clk);
    wr_reg(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
